// file: pbws_fan_ctrl.sv
// Closed-loop thermal fan control, one loop per fan.
// Assumes temperatures are synchronous to clk_sys.
`timescale 1ns/10ps
module pbws_fan_ctrl #(
  parameter int         N       = pbws_pkg::FAN_NUM,
  parameter logic [7:0] TEMP_LO = pbws_pkg::TEMP_LO,
  parameter logic [7:0] TEMP_HI = pbws_pkg::TEMP_HI
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // Fan group
  pbws_fan_if.ctrl  fan
);

  logic [pbws_pkg::TICK_W-1:0] tick_cnt_q, tick_cnt_d;
  logic                        tick_q, tick_d;
  logic [7:0]                  duty_q [N];
  logic [7:0]                  duty_d [N];
  logic [N-1:0]                on_q, on_d;
  logic [7:0]                  tgt    [N];

  // Duty target from temperature, zero means fan off
  function automatic logic [7:0] target_duty(input logic [7:0] t);
    logic [9:0] s;
    s = {2'b00, t - TEMP_LO} << 2;
    if (t <= TEMP_LO) return 8'h00;
    if (t >= TEMP_HI) return pbws_pkg::DUTY_FULL;
    return (s > 10'h0FF) ? pbws_pkg::DUTY_FULL : s[7:0];
  endfunction

  // Ramp each duty one step per tick toward its target
  always_comb begin
    tick_d     = 1'b0;
    tick_cnt_d = tick_cnt_q + 1'b1;
    if (tick_cnt_q == pbws_pkg::TICK_W'(pbws_pkg::FAN_TICK_CYC - 1)) begin
      tick_cnt_d = '0;
      tick_d     = 1'b1;
    end
    for (int i = 0; i < N; i++) begin
      tgt[i]    = target_duty(fan.temp[i]);
      duty_d[i] = duty_q[i];
      if (!fan.run) begin
        duty_d[i] = pbws_pkg::DUTY_RESET;
      end else if (tick_q && duty_q[i] < tgt[i]) begin
        duty_d[i] = duty_q[i] + 8'h01;
      end else if (tick_q && duty_q[i] > tgt[i]) begin
        duty_d[i] = duty_q[i] - 8'h01;
      end
      on_d[i] = fan.run && (duty_d[i] != 8'h00);
    end
  end

  // Fan state registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
      on_q       <= '0;
      for (int i = 0; i < N; i++) duty_q[i] <= pbws_pkg::DUTY_RESET;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tick_q     <= tick_d;
      on_q       <= on_d;
      for (int i = 0; i < N; i++) duty_q[i] <= duty_d[i];
    end
  end

  assign fan.duty = duty_q;
  assign fan.on   = on_q;

  property p_fan_off;
    @(posedge clk_sys) disable iff (!reset_n)
    !fan.run |=> (on_q == '0) && (duty_q[0] == 8'h00);
  endproperty
  a_fan_off: assert property (p_fan_off)
    else $error("fan still running outside working state");

  property p_fan_ramp;
    @(posedge clk_sys) disable iff (!reset_n)
    fan.run && tick_q && (duty_q[0] < tgt[0])
      |=> duty_q[0] == $past(duty_q[0]) + 8'h01;
  endproperty
  a_fan_ramp: assert property (p_fan_ramp)
    else $error("fan duty did not step toward target");

endmodule // pbws_fan_ctrl

// file: pbws_fan_if.sv
// Interface carrying fan run enable, temperatures and fan drive.
// Assumes the sequencer drives run and temp, the fan loop the rest.
`timescale 1ns/10ps
interface pbws_fan_if #(
  parameter int N = 3
);
  logic       run;
  logic [7:0] temp [N];
  logic [7:0] duty [N];
  logic [N-1:0] on;

  modport seq  (output run, output temp, input duty, input on);
  modport ctrl (input run, input temp, output duty, output on);
endinterface // pbws_fan_if

// file: pbws_panel_model.sv
// Behavioural model of the front panel switch, wake sources and cover switch.
// Assumes the bench calls its tasks; lines change 1 ns after clk_sys rises.
`timescale 1ns/10ps
module pbws_panel_model (
  // Clock
  input  wire logic clk_sys,
  // Pins toward the sequencer
  output logic      pwr_sw_n,
  output logic      rtc_alarm,
  output logic      pcie_wake_n,
  output logic      lan_wake,
  output logic      pme_n,
  output logic      ps2_act,
  output logic      serial_act,
  output logic      usb_act,
  output logic      intrusion_closed
);

  // Idle levels: switch open on its pull-up, no wake, cover fitted
  initial begin
    pwr_sw_n         = 1'b1;
    rtc_alarm        = 1'b0;
    pcie_wake_n      = 1'b1;
    lan_wake         = 1'b0;
    pme_n            = 1'b1;
    ps2_act          = 1'b0;
    serial_act       = 1'b0;
    usb_act          = 1'b0;
    intrusion_closed = 1'b0;
  end

  // Set one source active or idle, honouring each line's polarity
  task automatic drive(input int src, input logic act);
    @(posedge clk_sys);
    #1;
    case (src)
      pbws_pkg::WAKE_PWR:  pwr_sw_n    = ~act;
      pbws_pkg::WAKE_RTC:  rtc_alarm   = act;
      pbws_pkg::WAKE_PCIE: pcie_wake_n = ~act;
      pbws_pkg::WAKE_LAN:  lan_wake    = act;
      pbws_pkg::WAKE_PME:  pme_n       = ~act;
      pbws_pkg::WAKE_PS2:  ps2_act     = act;
      pbws_pkg::WAKE_SER:  serial_act  = act;
      pbws_pkg::WAKE_USB:  usb_act     = act;
      default:             intrusion_closed = act; // Closed reads high
    endcase
  endtask

  // Hold the switch down for n cycles, then let it spring open
  task automatic press(input int n);
    drive(pbws_pkg::WAKE_PWR, 1'b1);
    repeat (n) @(posedge clk_sys);
    #1 pwr_sw_n = 1'b1;
  endtask

endmodule // pbws_panel_model

// file: pbws_pkg.sv
// Shared constants and types for the power button and wake sequencer.
// Assumes a single always-on standby clock of 250 MHz.
package pbws_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_PS  = 4000;
  localparam int CYC_PER_MS     = 1000000000 / CLK_PERIOD_PS;
  localparam int LONG_PRESS_MS  = 4000;
  localparam int LONG_PRESS_CYC = LONG_PRESS_MS * CYC_PER_MS;
  localparam int DEBOUNCE_MS    = 20;
  localparam int DEBOUNCE_CYC   = DEBOUNCE_MS * CYC_PER_MS;
  localparam int FAN_TICK_NS    = 1000;
  localparam int FAN_TICK_CYC   = (FAN_TICK_NS * 1000) / CLK_PERIOD_PS;
  localparam int CNT_W          = 30;
  localparam int TICK_W         = 16;

  // Wake source bit positions
  localparam int WAKE_PWR  = 0;
  localparam int WAKE_RTC  = 1;
  localparam int WAKE_PCIE = 2;
  localparam int WAKE_LAN  = 3;
  localparam int WAKE_PME  = 4;
  localparam int WAKE_PS2  = 5;
  localparam int WAKE_SER  = 6;
  localparam int WAKE_USB  = 7;
  localparam int WAKE_NUM  = 8;

  // Pin vector: wake sources 0..7, intrusion switch 8
  localparam int PIN_INTR  = 8;
  localparam int PIN_NUM   = 9;
  localparam logic [8:0] PIN_IDLE = 9'h000;

  // Fan defaults
  localparam int FAN_NUM            = 3;
  localparam logic [7:0] TEMP_LO    = 8'h28;
  localparam logic [7:0] TEMP_HI    = 8'h50;
  localparam logic [7:0] DUTY_RESET = 8'h00;
  localparam logic [7:0] DUTY_FULL  = 8'hFF;

  // Global power state
  typedef enum logic [1:0] {
    ST_SOFT_OFF,
    ST_WORKING,
    ST_SLEEPING
  } pbws_state_type;

endpackage

// file: pbws_sequencer.sv
// Power state sequencer: power switch timing, wake gating, intrusion, fans.
// Assumes all pins are asynchronous; config and clear inputs are on clk_sys.
//
// Overview of operation
// - In soft-off a power switch press under four seconds powers the system on.
// - In working a press under four seconds sends the system to sleep.
// - In working a hold over four seconds forces soft-off above software.
// - In sleep a press under four seconds wakes the system to working.
// - In sleep a hold over four seconds goes straight to soft-off.
// - Power switch, RTC alarm and PCIe wake may wake from S3, S4 and S5.
// - PS/2, serial and USB activity wake only from S3 and are ignored otherwise.
// - LAN and PME wake from S3 or S4, and from S5 only when enabled.
// - A closed intrusion switch raises the chassis intrusion flag.
// - Each of the three fans runs a closed thermal loop on its temperature.
// - Fans run in S0 and are held off in every other state.
`timescale 1ns/10ps
module pbws_sequencer #(
  parameter int LONG_CYC = pbws_pkg::LONG_PRESS_CYC,
  parameter int DEB_CYC  = pbws_pkg::DEBOUNCE_CYC,
  parameter int FANS     = pbws_pkg::FAN_NUM
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  // Front panel and wake pins, asynchronous
  input  wire logic              pwr_sw_n,
  input  wire logic              rtc_alarm,
  input  wire logic              pcie_wake_n,
  input  wire logic              lan_wake,
  input  wire logic              pme_n,
  input  wire logic              ps2_act,
  input  wire logic              serial_act,
  input  wire logic              usb_act,
  input  wire logic              intrusion_closed,
  // Configuration and software requests
  input  wire logic              s5_lan_pme_en,
  input  wire logic              sleep_to_disk,
  input  wire logic              os_sleep_req,
  input  wire logic              os_off_req,
  input  wire logic [7:0]        wake_clr,
  input  wire logic              intrusion_clr,
  // Temperatures, one byte per fan
  input  wire logic [FANS*8-1:0] fan_temp,
  // Power state
  output logic [1:0]             pwr_state,
  output logic                   sys_on,
  output logic                   sleep_deep,
  // Event flags
  output logic [7:0]             wake_flags,
  output logic                   intrusion_flag,
  // Fan drive
  output logic [FANS*8-1:0]      fan_duty,
  output logic [FANS-1:0]        fan_on
);

  localparam logic [pbws_pkg::CNT_W-1:0] LONG_M1 =
    pbws_pkg::CNT_W'(LONG_CYC - 1);
  localparam logic [pbws_pkg::CNT_W-1:0] DEB_M1 =
    pbws_pkg::CNT_W'(DEB_CYC - 1);

  // Pin synchronisers
  logic [pbws_pkg::PIN_NUM-1:0] pin_raw;
  logic [pbws_pkg::PIN_NUM-1:0] sync1_q, sync2_q, sync3_q;
  logic [pbws_pkg::PIN_NUM-1:0] pin_act_q, pin_act_d;

  // Switch debounce and timing
  logic                        btn_q, btn_d;
  logic [pbws_pkg::CNT_W-1:0]  deb_cnt_q, deb_cnt_d;
  logic [pbws_pkg::CNT_W-1:0]  hold_cnt_q, hold_cnt_d;
  logic                        long_done_q, long_done_d;
  logic                        short_evt_q, short_evt_d;
  logic                        long_evt_q, long_evt_d;

  // Power state and flags
  pbws_pkg::pbws_state_type    state_q, state_d;
  logic                        deep_q, deep_d;
  logic [7:0]                  flags_q, flags_d;
  logic                        intr_q, intr_d;
  logic                        sys_on_q, sys_on_d;
  logic [7:0]                  allow;

  pbws_fan_if #(.N(FANS)) fif ();

  // Active-high view of the pins
  assign pin_raw = {intrusion_closed, usb_act, serial_act, ps2_act,
                    ~pme_n, lan_wake, ~pcie_wake_n, rtc_alarm, ~pwr_sw_n};

  // Wake sources allowed in the given state
  function automatic logic [7:0] wake_allow(input pbws_pkg::pbws_state_type s,
                                            input logic deep,
                                            input logic s5_en);
    logic [7:0] m;
    m = '0;
    if (s != pbws_pkg::ST_WORKING) begin
      m[pbws_pkg::WAKE_PWR]  = 1'b1;
      m[pbws_pkg::WAKE_RTC]  = 1'b1;
      m[pbws_pkg::WAKE_PCIE] = 1'b1;
      m[pbws_pkg::WAKE_LAN]  = (s == pbws_pkg::ST_SLEEPING) || s5_en;
      m[pbws_pkg::WAKE_PME]  = (s == pbws_pkg::ST_SLEEPING) || s5_en;
    end
    if (s == pbws_pkg::ST_SLEEPING && !deep) begin
      m[pbws_pkg::WAKE_PS2] = 1'b1;
      m[pbws_pkg::WAKE_SER] = 1'b1;
      m[pbws_pkg::WAKE_USB] = 1'b1;
    end
    return m;
  endfunction

  // A pin change counts once stages two and three agree
  always_comb begin
    pin_act_d = (sync2_q & sync3_q) | (pin_act_q & (sync2_q ^ sync3_q));
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q   <= pbws_pkg::PIN_IDLE;
      sync2_q   <= pbws_pkg::PIN_IDLE;
      sync3_q   <= pbws_pkg::PIN_IDLE;
      pin_act_q <= pbws_pkg::PIN_IDLE;
    end else begin
      sync1_q   <= pin_raw;
      sync2_q   <= sync1_q;
      sync3_q   <= sync2_q;
      pin_act_q <= pin_act_d;
    end
  end

  // Debounce the switch, time the hold, emit short and long pulses
  always_comb begin
    btn_d       = btn_q;
    deb_cnt_d   = '0;
    hold_cnt_d  = '0;
    long_done_d = long_done_q;
    short_evt_d = 1'b0;
    long_evt_d  = 1'b0;
    if (pin_act_q[pbws_pkg::WAKE_PWR] != btn_q) begin
      deb_cnt_d = deb_cnt_q + 1'b1;
      if (deb_cnt_q >= DEB_M1) begin
        btn_d     = ~btn_q;
        deb_cnt_d = '0;
      end
    end
    if (btn_q && btn_d) begin
      hold_cnt_d = (hold_cnt_q > LONG_M1) ? hold_cnt_q : hold_cnt_q + 1'b1;
      if (hold_cnt_q == LONG_M1 && !long_done_q) begin
        long_evt_d  = 1'b1;
        long_done_d = 1'b1;
      end
    end
    if (btn_q && !btn_d) begin
      short_evt_d = !long_done_q;
      long_done_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      btn_q       <= 1'b0;
      deb_cnt_q   <= '0;
      hold_cnt_q  <= '0;
      long_done_q <= 1'b0;
      short_evt_q <= 1'b0;
      long_evt_q  <= 1'b0;
    end else begin
      btn_q       <= btn_d;
      deb_cnt_q   <= deb_cnt_d;
      hold_cnt_q  <= hold_cnt_d;
      long_done_q <= long_done_d;
      short_evt_q <= short_evt_d;
      long_evt_q  <= long_evt_d;
    end
  end

  // Power state, sticky wake flags and intrusion flag
  always_comb begin
    allow    = wake_allow(state_q, deep_q, s5_lan_pme_en);
    state_d  = state_q;
    deep_d   = deep_q;
    flags_d  = flags_q & ~wake_clr;
    intr_d   = (intr_q && !intrusion_clr) || pin_act_q[pbws_pkg::PIN_INTR];
    // Switch wake counts on release, others on assertion
    flags_d  = flags_d | (pin_act_q[7:0] & allow & 8'hFE);
    if (short_evt_q && allow[pbws_pkg::WAKE_PWR]) begin
      flags_d[pbws_pkg::WAKE_PWR] = 1'b1;
    end
    case (state_q)
      pbws_pkg::ST_SOFT_OFF: begin
        if (short_evt_q || |(pin_act_q[7:0] & allow & 8'hFE)) begin
          state_d = pbws_pkg::ST_WORKING;
        end
      end
      pbws_pkg::ST_WORKING: begin
        if (long_evt_q || os_off_req) begin
          state_d = pbws_pkg::ST_SOFT_OFF;
        end else if (short_evt_q || os_sleep_req) begin
          state_d = pbws_pkg::ST_SLEEPING;
          deep_d  = sleep_to_disk;
        end
      end
      pbws_pkg::ST_SLEEPING: begin
        if (long_evt_q) begin
          state_d = pbws_pkg::ST_SOFT_OFF;
        end else if (short_evt_q || |(pin_act_q[7:0] & allow & 8'hFE)) begin
          state_d = pbws_pkg::ST_WORKING;
        end
      end
      default: state_d = pbws_pkg::ST_SOFT_OFF;
    endcase
    sys_on_d = (state_d == pbws_pkg::ST_WORKING);
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q  <= pbws_pkg::ST_SOFT_OFF;
      deep_q   <= 1'b0;
      flags_q  <= 8'h00;
      intr_q   <= 1'b0;
      sys_on_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      deep_q   <= deep_d;
      flags_q  <= flags_d;
      intr_q   <= intr_d;
      sys_on_q <= sys_on_d;
    end
  end

  // Fan loop hookup, run only while working
  always_comb begin
    fif.run = sys_on_q;
    for (int i = 0; i < FANS; i++) begin
      fif.temp[i] = fan_temp[i*8 +: 8];
      fan_duty[i*8 +: 8] = fif.duty[i];
    end
  end

  pbws_fan_ctrl #(
    .N       (FANS)
  ) u_fan (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .fan     (fif.ctrl)
  );

  assign fan_on         = fif.on;
  assign pwr_state      = state_q;
  assign sys_on         = sys_on_q;
  assign sleep_deep     = deep_q;
  assign wake_flags     = flags_q;
  assign intrusion_flag = intr_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_in_state(pbws_pkg::pbws_state_type s);
    state_q == s;
  endsequence

  sequence s_short_in(pbws_pkg::pbws_state_type s);
    s_in_state(s) ##0 short_evt_q;
  endsequence

  property p_off_on;
    s_short_in(pbws_pkg::ST_SOFT_OFF) |=> state_q == pbws_pkg::ST_WORKING
      && fif.run;
  endproperty
  a_off_on: assert property (p_off_on)
    else $error("short press in soft-off did not power on");

  property p_work_sleep;
    s_short_in(pbws_pkg::ST_WORKING) ##0 (!long_evt_q && !os_off_req)
      |=> state_q == pbws_pkg::ST_SLEEPING;
  endproperty
  a_work_sleep: assert property (p_work_sleep)
    else $error("short press in working did not sleep");

  property p_work_off;
    s_in_state(pbws_pkg::ST_WORKING) ##0 long_evt_q
      |=> state_q == pbws_pkg::ST_SOFT_OFF && !sys_on_q;
  endproperty
  a_work_off: assert property (p_work_off)
    else $error("long hold in working did not force soft-off");

  property p_sleep_wake;
    s_short_in(pbws_pkg::ST_SLEEPING) |=> state_q == pbws_pkg::ST_WORKING
      && flags_q[pbws_pkg::WAKE_PWR];
  endproperty
  a_sleep_wake: assert property (p_sleep_wake)
    else $error("short press in sleep did not wake");

  property p_sleep_off;
    s_in_state(pbws_pkg::ST_SLEEPING) ##0 long_evt_q
      |=> state_q == pbws_pkg::ST_SOFT_OFF;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("long hold in sleep did not go to soft-off");

  property p_rtc_wake;
    state_q != pbws_pkg::ST_WORKING && pin_act_q[pbws_pkg::WAKE_RTC]
      && !long_evt_q |=> state_q == pbws_pkg::ST_WORKING
      && flags_q[pbws_pkg::WAKE_RTC];
  endproperty
  a_rtc_wake: assert property (p_rtc_wake)
    else $error("RTC alarm did not wake");

  property p_usb_s3_only;
    !(state_q == pbws_pkg::ST_SLEEPING && !deep_q)
      && !flags_q[pbws_pkg::WAKE_USB] |=> !flags_q[pbws_pkg::WAKE_USB];
  endproperty
  a_usb_s3_only: assert property (p_usb_s3_only)
    else $error("USB wake accepted outside S3");

  property p_lan_s5_gate;
    state_q == pbws_pkg::ST_SOFT_OFF && !s5_lan_pme_en
      && !flags_q[pbws_pkg::WAKE_LAN] |=> !flags_q[pbws_pkg::WAKE_LAN];
  endproperty
  a_lan_s5_gate: assert property (p_lan_s5_gate)
    else $error("LAN wake accepted in S5 while disabled");

  property p_intrusion;
    pin_act_q[pbws_pkg::PIN_INTR] |=> intr_q;
  endproperty
  a_intrusion: assert property (p_intrusion)
    else $error("closed intrusion switch not flagged");

  property p_long_at_limit;
    long_evt_q |-> $past(hold_cnt_q) == LONG_M1 && btn_q;
  endproperty
  a_long_at_limit: assert property (p_long_at_limit)
    else $error("long press pulse not at the hold limit");

  property p_short_on_release;
    short_evt_q |-> !btn_q && $past(btn_q) && !$past(long_done_q);
  endproperty
  a_short_on_release: assert property (p_short_on_release)
    else $error("short press pulse not at release");

  property p_flag_sticky;
    flags_q[pbws_pkg::WAKE_PCIE] && !wake_clr[pbws_pkg::WAKE_PCIE]
      |=> flags_q[pbws_pkg::WAKE_PCIE];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("wake flag dropped without a clear");

endmodule // pbws_sequencer

// file: power_button_wake_sequencer_tb.sv
// Self-checking bench for the power switch and wake sequencer.
// Assumes pbws_pkg, pbws_panel_model and the sequencer are compiled first.
`timescale 1ns/10ps
module power_button_wake_sequencer_tb;

  localparam pbws_pkg::pbws_state_type OFF_ST = pbws_pkg::ST_SOFT_OFF;
  localparam pbws_pkg::pbws_state_type ON_ST  = pbws_pkg::ST_WORKING;
  localparam pbws_pkg::pbws_state_type SLP_ST = pbws_pkg::ST_SLEEPING;

  // One wake-gating case: state to reach and sources it must accept
  typedef struct {
    pbws_pkg::pbws_state_type st;
    logic                     deep;
    logic                     en;
    logic [7:0]               mask;
  } pbws_row_type;

  // Bench signals
  logic        clk_sys, reset_n, s5_lan_pme_en, sleep_to_disk;
  logic        os_sleep_req, os_off_req, intrusion_clr;
  logic [7:0]  wake_clr;
  logic [23:0] fan_temp;
  logic        pwr_sw_n, rtc_alarm, pcie_wake_n, lan_wake, pme_n;
  logic        ps2_act, serial_act, usb_act, intrusion_closed;
  logic [1:0]  pwr_state;
  logic        sys_on, sleep_deep, intrusion_flag;
  logic [7:0]  wake_flags;
  logic [23:0] fan_duty;
  logic [2:0]  fan_on;
  int          err_total, tests_run;

  pbws_row_type rows [4] = '{
    '{OFF_ST, 1'b0, 1'b0, 8'h06},
    '{OFF_ST, 1'b0, 1'b1, 8'h1E},
    '{SLP_ST, 1'b0, 1'b0, 8'hFE},
    '{SLP_ST, 1'b1, 1'b0, 8'h1E}
  };

  // Free-running standby clock
  initial clk_sys = 1'b0;
  always #2 clk_sys = ~clk_sys;

  pbws_panel_model model_u (
    .clk_sys(clk_sys), .pwr_sw_n(pwr_sw_n), .rtc_alarm(rtc_alarm),
    .pcie_wake_n(pcie_wake_n), .lan_wake(lan_wake), .pme_n(pme_n),
    .ps2_act(ps2_act), .serial_act(serial_act), .usb_act(usb_act),
    .intrusion_closed(intrusion_closed)
  );

  pbws_sequencer #(.LONG_CYC(64), .DEB_CYC(4)) dut_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .pwr_sw_n(pwr_sw_n),
    .rtc_alarm(rtc_alarm), .pcie_wake_n(pcie_wake_n), .lan_wake(lan_wake),
    .pme_n(pme_n), .ps2_act(ps2_act), .serial_act(serial_act),
    .usb_act(usb_act), .intrusion_closed(intrusion_closed),
    .s5_lan_pme_en(s5_lan_pme_en), .sleep_to_disk(sleep_to_disk),
    .os_sleep_req(os_sleep_req), .os_off_req(os_off_req),
    .wake_clr(wake_clr), .intrusion_clr(intrusion_clr),
    .fan_temp(fan_temp), .pwr_state(pwr_state), .sys_on(sys_on),
    .sleep_deep(sleep_deep), .wake_flags(wake_flags),
    .intrusion_flag(intrusion_flag), .fan_duty(fan_duty), .fan_on(fan_on)
  );

  // Advance n edges and land just after the last one
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d of %0d checks", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Bounded wait for a power state
  task automatic wait_st(input pbws_pkg::pbws_state_type exp);
    int i;
    for (i = 0; i < 200 && pwr_state !== exp; i++) step(1);
    if (pwr_state !== exp) begin
      err_total++;
      $display("mismatch at %0t: state wait timed out", $time);
      finish_test();
    end
  endtask

  task automatic do_reset();
    @(posedge clk_sys);
    #1 reset_n = 1'b0;
    step(20);
    reset_n = 1'b1;
  endtask

  task automatic go_sleep();
    os_sleep_req = 1'b1;
    step(1);
    os_sleep_req = 1'b0;
    wait_st(SLP_ST);
  endtask

  // Main sequence
  initial begin
    int   r, s;
    logic acc;
    reset_n = 1'b0; s5_lan_pme_en = 1'b0; sleep_to_disk = 1'b0;
    os_sleep_req = 1'b0; os_off_req = 1'b0; intrusion_clr = 1'b0;
    wake_clr = 8'h00; fan_temp = {8'h30, 8'h60, 8'h20};
    err_total = 0; tests_run = 0;
    step(20);
    reset_n = 1'b1;
    // Wake gating per state and source
    for (r = 0; r < 4; r++) begin
      for (s = 1; s < 8; s++) begin
        do_reset();
        s5_lan_pme_en = rows[r].en;
        sleep_to_disk = rows[r].deep;
        if (rows[r].st == SLP_ST) begin
          model_u.press(16);
          wait_st(ON_ST);
          go_sleep();
          chk(sleep_deep === rows[r].deep, "sleep depth");
        end
        wake_clr = 8'hFF;
        step(1);
        wake_clr = 8'h00;
        model_u.drive(s, 1'b1);
        step(12);
        model_u.drive(s, 1'b0);
        acc = rows[r].mask[s];
        chk(wake_flags === (acc ? 8'h01 << s : 8'h00), "flag");
        chk(pwr_state === (acc ? ON_ST : rows[r].st), "state");
      end
    end
    // Reset values
    do_reset();
    chk(pwr_state === OFF_ST && sys_on === 1'b0 && wake_flags === 8'h00 &&
        fan_duty === 24'h000000 && fan_on === 3'h0, "reset");
    // Short glitch filtered, long hold from soft-off ignored
    model_u.press(2);
    model_u.press(120);
    step(30);
    chk(pwr_state === OFF_ST && wake_flags === 8'h00, "off hold");
    // Short press acts only at release
    model_u.drive(pbws_pkg::WAKE_PWR, 1'b1);
    step(30);
    chk(pwr_state === OFF_ST, "early act");
    model_u.drive(pbws_pkg::WAKE_PWR, 1'b0);
    wait_st(ON_ST);
    chk(sys_on === 1'b1 && wake_flags === 8'h01, "power on");
    // Fans ramp toward their targets
    step(8300);
    chk(fan_duty[23:16] === 8'h20 && fan_duty[7:0] === 8'h00, "duty");
    chk(fan_duty[15:8] >= 8'h20 && fan_duty[15:8] <= 8'h22, "ramp");
    chk(fan_on === 3'b110 && wake_flags === 8'h01, "fan on");
    // Warmer fan 0 ramps up to a small duty and starts
    fan_temp[7:0] = 8'h29;
    step(1100);
    chk(fan_duty[7:0] === 8'h04 && fan_on === 3'b111, "temp rise");
    wake_clr = 8'h01;
    step(1);
    wake_clr = 8'h00;
    step(1);
    chk(wake_flags === 8'h00, "flag clear");
    // Software off request, then power back on
    os_off_req = 1'b1;
    step(1);
    os_off_req = 1'b0;
    chk(pwr_state === OFF_ST && sys_on === 1'b0, "os off");
    model_u.press(16);
    wait_st(ON_ST);
    // Short press to deep sleep, fans stop
    sleep_to_disk = 1'b1;
    model_u.press(16);
    wait_st(SLP_ST);
    step(2);
    chk(sleep_deep === 1'b1 && sys_on === 1'b0, "sleep");
    chk(fan_duty === 24'h000000 && fan_on === 3'h0, "fans off");
    model_u.press(16);
    wait_st(ON_ST);
    chk(sys_on === 1'b1, "wake press");
    // Long hold in working forces soft-off while held
    model_u.drive(pbws_pkg::WAKE_PWR, 1'b1);
    step(50);
    chk(pwr_state === ON_ST, "long early");
    wait_st(OFF_ST);
    model_u.drive(pbws_pkg::WAKE_PWR, 1'b0);
    step(30);
    chk(pwr_state === OFF_ST && sys_on === 1'b0, "long off");
    // Long hold in sleep goes to soft-off
    model_u.drive(pbws_pkg::WAKE_RTC, 1'b1);
    wait_st(ON_ST);
    model_u.drive(pbws_pkg::WAKE_RTC, 1'b0);
    step(6); // Alarm must leave the synchroniser before sleeping
    go_sleep();
    step(4);
    chk(pwr_state === SLP_ST, "still asleep");
    model_u.drive(pbws_pkg::WAKE_PWR, 1'b1);
    wait_st(OFF_ST);
    model_u.drive(pbws_pkg::WAKE_PWR, 1'b0);
    step(30);
    chk(pwr_state === OFF_ST, "sleep long");
    // Cover removal flag, sticky until cleared
    model_u.drive(pbws_pkg::PIN_INTR, 1'b1);
    step(10);
    model_u.drive(pbws_pkg::PIN_INTR, 1'b0);
    step(10);
    chk(intrusion_flag === 1'b1, "intrusion");
    intrusion_clr = 1'b1;
    step(1);
    intrusion_clr = 1'b0;
    step(1);
    chk(intrusion_flag === 1'b0, "intr clear");
    finish_test();
  end

endmodule // power_button_wake_sequencer_tb
